/* core/drive_type2_message_codec.sv */
// type 2 command decoder and response builder
// Operation
// - read-back data only in type 2 responses
// - returned values are 16 or 32 bits
// - response echoes opcode and operand unchanged
// - status code unless opcode requests data
// - status code is a bit pattern
// - response byte 0 zero, axis 0, type 2
// - byte 2 opcode, byte 3 operand
// - status in bytes 4-5; 0x84/0x89 data
// - 0x9F returns 32-bit data MSB first
// - bytes 6-7 zero unless 32-bit data
// - 0x83 writes 16-bit parameter, returns status
// - 0x84 reads 16-bit parameter
// - 0x88 operand 1 returns absolute position
// - parameter 0x1E is acceleration rate
// - 0x88 operand 0 returns encoder position
// - 0x9F/0x9E read/write 32-bit user register
`timescale 1ns/1ps
`include "msg_codec_map.svh"
module drive_type2_message_codec (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_valid, // command message offered
	input msg_codec_pkg::msg_t cmd_msg, // command message
	output logic cmd_ready_q, // codec can take a command
	output logic rsp_valid_q, // response message held
	output msg_codec_pkg::msg_t rsp_msg_q, // response message
	input wire logic rsp_ready, // host takes the response
	input msg_codec_pkg::drive_vals_t drive_vals, // live drive values
	output logic [7:0] param_sel_q, // parameter code of last access
	output logic param_wr_q, // pulse: write other parameter
	output logic [15:0] param_wdata_q, // parameter write value
	output logic [15:0] accel_rate_setting_q, // accel, 10 rpm/s units
	output logic ureg_wr_q, // pulse: user register write
	output logic [7:0] ureg_sel_q, // user register code
	output logic [31:0] ureg_wdata_q // user register write value
);
	import msg_codec_pkg::*;

	codec_state_t state_q, state_d; // handshake state
	msg_t rsp_d; // next response
	logic [7:0] param_sel_d; // next parameter code
	logic param_wr_d; // next parameter write strobe
	logic [15:0] param_wdata_d; // next parameter data
	logic [15:0] accel_d; // next accel setting
	logic ureg_wr_d; // next user write strobe
	logic [7:0] ureg_sel_d; // next user register code
	logic [31:0] ureg_wdata_d; // next user write data
	logic take; // command accepted this cycle
	logic is_type2; // command header is type 2, axis 0, byte 0 zero

	// accepted type 2 header check
	function automatic logic hdr_ok(input msg_t m);
		hdr_ok = (m.rsvd == `MSG_RSVD_BYTE) && (m.axis == `MSG_AXIS_NUM)
			&& (m.mtype == `MSG_TYPE_TWO);
	endfunction : hdr_ok

	// refused while a response waits and before the first edge after reset
	assign take = cmd_valid && cmd_ready_q;
	assign is_type2 = hdr_ok(cmd_msg);

	// next state, response and side effects
	always_comb begin
		state_d = state_q;
		rsp_d = rsp_msg_q;
		param_sel_d = param_sel_q;
		param_wr_d = 1'b0;
		param_wdata_d = param_wdata_q;
		accel_d = accel_rate_setting_q;
		ureg_wr_d = 1'b0;
		ureg_sel_d = ureg_sel_q;
		ureg_wdata_d = ureg_wdata_q;
		case (state_q)
			ST_IDLE: begin
				// other message types are dropped, no answer
				if (take && is_type2) begin
					state_d = ST_RESP;
					rsp_d.rsvd = `MSG_RSVD_BYTE;
					rsp_d.axis = `MSG_AXIS_NUM;
					rsp_d.mtype = `MSG_TYPE_TWO;
					rsp_d.opcode = cmd_msg.opcode;
					rsp_d.operand = cmd_msg.operand;
					// default: status in 4-5, zeros in 6-7
					rsp_d.data = {drive_vals.status, 16'h0000};
					case (cmd_msg.opcode)
						`OP_PARAM_WRITE: begin
							// 16-bit value from bytes 4-5
							param_sel_d = cmd_msg.operand;
							param_wdata_d = cmd_msg.data[31:16];
							if (cmd_msg.operand == `PARAM_ACCEL) begin
								accel_d = cmd_msg.data[31:16];
							end else begin
								param_wr_d = 1'b1;
							end
						end
						`OP_PARAM_READ, `OP_READ_89: begin
							// 16-bit read data, bytes 6-7 zero
							param_sel_d = cmd_msg.operand;
							if (cmd_msg.opcode == `OP_PARAM_READ &&
								cmd_msg.operand == `PARAM_ACCEL) begin
								rsp_d.data = {accel_rate_setting_q, 16'h0000};
							end else begin
								rsp_d.data = {drive_vals.param_rd, 16'h0000};
							end
						end
						`OP_POS_READ: begin
							// 32-bit position for operand 0 or 1, status for other operands
							if (cmd_msg.operand == `OPND_ABS_POS) begin
								rsp_d.data = drive_vals.abs_pos;
							end else if (cmd_msg.operand == `OPND_ENC_POS) begin
								rsp_d.data = drive_vals.enc_pos;
							end else begin
								rsp_d.data = {drive_vals.status, 16'h0000};
							end
						end
						`OP_UREG_READ: begin
							ureg_sel_d = cmd_msg.operand;
							rsp_d.data = drive_vals.ureg_rd;
						end
						`OP_UREG_WRITE: begin
							// 32-bit data across bytes 4-7
							ureg_sel_d = cmd_msg.operand;
							ureg_wdata_d = cmd_msg.data;
							ureg_wr_d = 1'b1;
						end
						default: begin
							rsp_d.data = {drive_vals.status, 16'h0000};
						end
					endcase
				end
			end
			ST_RESP: begin
				// hold until taken, one response per command
				if (rsp_ready) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// register all state and outputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			rsp_msg_q <= '0;
			cmd_ready_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			param_sel_q <= 8'h00;
			param_wr_q <= 1'b0;
			param_wdata_q <= 16'h0000;
			accel_rate_setting_q <= `ACCEL_RESET;
			ureg_wr_q <= 1'b0;
			ureg_sel_q <= 8'h00;
			ureg_wdata_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			rsp_msg_q <= rsp_d;
			cmd_ready_q <= (state_d == ST_IDLE);
			rsp_valid_q <= (state_d == ST_RESP);
			param_sel_q <= param_sel_d;
			param_wr_q <= param_wr_d;
			param_wdata_q <= param_wdata_d;
			accel_rate_setting_q <= accel_d;
			ureg_wr_q <= ureg_wr_d;
			ureg_sel_q <= ureg_sel_d;
			ureg_wdata_q <= ureg_wdata_d;
		end
	end

	// checks on the response path and the accel setting
	property p_hdr;
		@(posedge clk_sys) disable iff (!rst_n)
		rsp_valid_q |-> rsp_msg_q.rsvd == 8'h00 && rsp_msg_q.axis == 4'h0
			&& rsp_msg_q.mtype == 4'h2;
	endproperty
	a_hdr: assert property (p_hdr) else $error("bad header");
	property p_echo;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && is_type2) |=> rsp_msg_q.opcode == $past(cmd_msg.opcode)
			&& rsp_msg_q.operand == $past(cmd_msg.operand);
	endproperty
	a_echo: assert property (p_echo) else $error("no echo");
	property p_one;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && is_type2) |=> rsp_valid_q && !cmd_ready_q;
	endproperty
	a_one: assert property (p_one) else $error("no response");
	property p_drop;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && !is_type2) |=> !rsp_valid_q;
	endproperty
	a_drop: assert property (p_drop) else $error("bad type answered");
	property p_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(rsp_valid_q && !rsp_ready) |=> rsp_valid_q && $stable(rsp_msg_q);
	endproperty
	a_hold: assert property (p_hold) else $error("response lost");
	property p_stat;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && is_type2 && cmd_msg.opcode == 8'h83) |=>
			rsp_msg_q.data == {$past(drive_vals.status), 16'h0000};
	endproperty
	a_stat: assert property (p_stat) else $error("status missing");
	property p_ureg;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && is_type2 && cmd_msg.opcode == 8'h9F) |=>
			rsp_msg_q.data == $past(drive_vals.ureg_rd);
	endproperty
	a_ureg: assert property (p_ureg) else $error("ureg data");
	property p_abs;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && is_type2 && cmd_msg.opcode == 8'h88 &&
			cmd_msg.operand == 8'h01) |=>
			rsp_msg_q.data == $past(drive_vals.abs_pos);
	endproperty
	a_abs: assert property (p_abs) else $error("abs pos");
	property p_low;
		@(posedge clk_sys) disable iff (!rst_n)
		(rsp_valid_q && rsp_msg_q.opcode == 8'h84) |->
			rsp_msg_q.data[15:0] == 16'h0000;
	endproperty
	a_low: assert property (p_low) else $error("bytes 6-7 set");
	property p_acc;
		@(posedge clk_sys) disable iff (!rst_n)
		(take && is_type2 && cmd_msg.opcode == 8'h83 &&
			cmd_msg.operand == 8'h1E) |=>
			accel_rate_setting_q == $past(cmd_msg.data[31:16]);
	endproperty
	a_acc: assert property (p_acc) else $error("accel write");
	c_wr: cover property (@(posedge clk_sys) ureg_wr_q);
	c_rd: cover property (@(posedge clk_sys)
		rsp_valid_q && rsp_msg_q.opcode == 8'h84);
	c_stall: cover property (@(posedge clk_sys) rsp_valid_q && !rsp_ready);
endmodule : drive_type2_message_codec

/* core/msg_codec_map.svh */
// constants for the type 2 message codec
`ifndef MSG_CODEC_MAP_SVH
`define MSG_CODEC_MAP_SVH
`define MSG_TYPE_TWO 4'h2
`define MSG_AXIS_NUM 4'h0
`define MSG_RSVD_BYTE 8'h00
`define OP_PARAM_WRITE 8'h83
`define OP_PARAM_READ 8'h84
`define OP_POS_READ 8'h88
`define OP_READ_89 8'h89
`define OP_UREG_WRITE 8'h9E
`define OP_UREG_READ 8'h9F
`define OPND_ENC_POS 8'h00
`define OPND_ABS_POS 8'h01
`define PARAM_ACCEL 8'h1E
`define ACCEL_RESET 16'h0000
`define STATUS_RESET 16'h0000
`endif

/* core/msg_codec_pkg.sv */
// types for the type 2 message codec
package msg_codec_pkg;
	// eight-byte message, byte 0 in the top bits
	typedef struct packed {
		logic [7:0] rsvd;
		logic [3:0] axis;
		logic [3:0] mtype;
		logic [7:0] opcode;
		logic [7:0] operand;
		logic [31:0] data;
	} msg_t;
	// drive-side values the codec reports
	typedef struct packed {
		logic [15:0] status;
		logic [31:0] abs_pos;
		logic [31:0] enc_pos;
		logic [15:0] param_rd;
		logic [31:0] ureg_rd;
	} drive_vals_t;
	// codec states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RESP = 2'b10
	} codec_state_t;
endpackage : msg_codec_pkg

/* dv/host_model.sv */
// host side: takes each response promptly or after a stall
`timescale 1ns/1ps
module host_model (
	input wire logic clk_sys,
	input wire logic rsp_valid_q,
	input wire logic slow,
	output logic rsp_ready
);
	logic [1:0] wait_q = 2'h0; // cycles a response has waited
	// one-cycle take, held until the sampling edge
	always @(posedge clk_sys) begin
		rsp_ready <= #1 rsp_valid_q && !rsp_ready && (wait_q == 2'h3 || !slow);
		wait_q <= rsp_valid_q ? wait_q + 2'h1 : 2'h0;
	end
endmodule : host_model

/* dv/testbench.sv */
// self-checking bench for the type 2 message codec
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	miscompares++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
	import msg_codec_pkg::*;
	logic clk_sys, rst_n, cmd_valid, rsp_ready, cmd_ready_q, rsp_valid_q;
	logic slow, param_wr_q, ureg_wr_q;
	msg_t cmd_msg, rsp_msg_q, e;
	drive_vals_t dv;
	logic [7:0] param_sel_q, ureg_sel_q;
	logic [15:0] param_wdata_q, accel_rate_setting_q, acc;
	logic [31:0] ureg_wdata_q;
	logic [39:0] uw; // expected user register write
	logic [23:0] pw; // expected parameter write
	msg_t exp_q[$]; // expected responses in order
	int miscompares = 0;
	int cmp_count = 0;
	logic [7:0] ops[8] = '{8'h83, 8'h84, 8'h88, 8'h89, 8'h9E, 8'h9F, 8'hFE,
		8'h01};
	drive_type2_message_codec i_drive_type2_message_codec (
		.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_msg(cmd_msg), .cmd_ready_q(cmd_ready_q),
		.rsp_valid_q(rsp_valid_q), .rsp_msg_q(rsp_msg_q),
		.rsp_ready(rsp_ready), .drive_vals(dv), .param_sel_q(param_sel_q),
		.param_wr_q(param_wr_q), .param_wdata_q(param_wdata_q),
		.accel_rate_setting_q(accel_rate_setting_q), .ureg_wr_q(ureg_wr_q),
		.ureg_sel_q(ureg_sel_q), .ureg_wdata_q(ureg_wdata_q));
	host_model i_host_model (.clk_sys(clk_sys), .rsp_valid_q(rsp_valid_q),
		.slow(slow), .rsp_ready(rsp_ready));
	// clock, 5 ns period
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	// note the expected response, then offer one command
	task automatic send(input logic [7:0] b1, op, od, input logic [31:0] d);
		msg_t x;
		msg_t c;
		int n;
		dv = {$urandom, $urandom, $urandom, $urandom};
		slow = 1'($urandom);
		x = {8'h00, 8'h02, op, od, dv.status, 16'h0000};
		if (op == 8'h84 || op == 8'h89)
			x.data[31:16] = dv.param_rd;
		if (op == 8'h84 && od == 8'h1E) x.data[31:16] = acc;
		if (op == 8'h88 && od == 8'h00) x.data = dv.enc_pos;
		if (op == 8'h88 && od == 8'h01) x.data = dv.abs_pos;
		if (op == 8'h9F) x.data = dv.ureg_rd;
		if (b1 == 8'h02) exp_q.push_back(x);
		n = 0;
		// at least one edge between two commands, then wait for ready
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (cmd_ready_q !== 1'b1 && n < 50);
		if (cmd_ready_q !== 1'b1) begin
			miscompares++;
			give_verdict();
		end
		c = {8'h00, b1, op, od, 32'h0000_0000};
		c.data = (op == 8'h9E) ? d : {d[31:16], 16'h0000};
		cmd_msg = c;
		cmd_valid = 1'b1;
		if (b1 == 8'h02 && op == 8'h9E) uw = {od, d};
		if (b1 == 8'h02 && op == 8'h83 && od == 8'h1E) acc = d[31:16];
		if (b1 == 8'h02 && op == 8'h83) pw = {od, d[31:16]};
		@(posedge clk_sys);
		#1 cmd_valid = 1'b0;
	endtask : send
	// scoreboard: oldest note against each response taken
	always @(posedge clk_sys) begin
		if (rsp_valid_q === 1'b1 && rsp_ready === 1'b1) begin
			if (exp_q.size() == 0) `CHK("extra rsp", 1'b0, 1'b1)
			else begin
				e = exp_q.pop_front();
				`CHK("rsp", e, rsp_msg_q)
				`CHK("busy", 1'b0, cmd_ready_q)
				if (e.opcode == 8'h9F) `CHK("usel", e.operand, ureg_sel_q)
				if (e.opcode == 8'h84 || e.opcode == 8'h89)
					`CHK("psel", e.operand, param_sel_q)
			end
		end
		if (ureg_wr_q === 1'b1) `CHK("ureg", uw, {ureg_sel_q, ureg_wdata_q})
		if (param_wr_q === 1'b1) `CHK("param", pw, {param_sel_q, param_wdata_q})
	end
	// hang guard
	initial begin
		#100000;
		miscompares++;
		give_verdict();
	end
	// main sequence
	initial begin
		void'($urandom(69931));
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_msg = '0;
		dv = '0;
		slow = 1'b0;
		acc = 16'h0000;
		repeat (20) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		@(posedge clk_sys);
		#1;
		send(8'h02, 8'h84, 8'h1E, 0);
		send(8'h02, 8'h83, 8'h1E, 32'h0258_0000);
		send(8'h02, 8'h84, 8'h1E, 0);
		send(8'h02, 8'h9E, 8'h44, 32'h1234_5678);
		send(8'h02, 8'h88, 8'h00, 0);
		send(8'h02, 8'h88, 8'h01, 0);
		send(8'h02, 8'h9F, 8'h33, 0);
		send(8'h12, 8'h84, 8'h10, 0);
		send(8'h01, 8'h88, 8'h01, 0);
		repeat (40) send(8'h02, ops[$urandom % 8], 8'($urandom), $urandom);
		for (int n = 0; n < 50 && exp_q.size() > 0; n++) @(posedge clk_sys);
		if (exp_q.size() > 0) miscompares++;
		repeat (3) @(posedge clk_sys);
		`CHK("accel", acc, accel_rate_setting_q)
		give_verdict();
	end
endmodule : testbench
